//--- common/drs_pkg.sv
// Package for the drive run/stop command logic: reset values, key codes, state codes, ratings.
// Assumes a single system clock and an asynchronous power-on reset.
package drs_pkg;
   localparam int unsigned REF_W = 16;
   localparam logic [15:0] REF_RESET = 16'h0000;
   localparam logic [15:0] REF_STEP_DEFAULT = 16'h0001;
   localparam logic [15:0] REF_MAX_DEFAULT = 16'hFFFF;
   localparam logic CMD_TYPE_RESET = 1'h0;
   localparam logic CMD_TWO_WIRE = 1'h0;
   localparam logic CMD_THREE_WIRE = 1'h1;
   localparam logic [1:0] MOTOR_RATING_RESET = 2'h2;
   localparam logic [1:0] MOTOR_RATING_LAST = 2'h2;
   localparam logic [1:0] SCREEN_RESET = 2'h0;

   typedef enum logic [3:0] {
      DRS_STOPPED  = 4'h1,
      DRS_RUNNING  = 4'h2,
      DRS_RAMPSTOP = 4'h4,
      DRS_FREEWHL  = 4'h8
   } drs_state_e;

   typedef struct packed {
      logic up;
      logic down;
      logic dec_point;
      logic confirm;
      logic escape;
      logic run;
      logic stop;
      logic fault_reset_softkey;
      logic screen_cycle_softkey;
   } drs_keys_s;

   typedef struct packed {
      logic enter_config;
      logic torque_type;
      logic torque_type_wr;
      logic command_type;
      logic command_type_wr;
      logic alternate_control_type;
      logic control_type_wr;
      logic motor_select;
      logic [1:0] motor_rating;
      logic motor_rating_wr;
   } drs_cfg_s;
endpackage

//--- logic/drs_run_stop.sv
// Run/stop command logic of a motor drive: keypad, terminal inputs, fault reset, config gating.
// Key and terminal inputs are synchronous one-clock pulses or levels from the keypad scanner.
// Functional notes
// - Keypad mode: up and down arrows change the reference immediately.
// - Keypad mode: decimal entry applies a typed reference only on confirm.
// - Keypad mode: a zero reference is still a running speed.
// - Run key latches run state; any reference including zero is then followed.
// - Keypad stop ramps output to zero; stored reference keeps its value.
// - Power-up clears the keypad reference and enters stopped state.
// - Fault-reset soft key clears a latched fault in keypad mode.
// - Scroll soft key cycles screens in keypad mode; arrows do it in terminal mode.
// - Configuration entry only when stopped; otherwise refusal shown until escape.
// - Changing torque or control type restores motor parameters to defaults.
// - Command type chooses 2-wire or 3-wire behaviour; default is 2-wire.
// - 2-wire: primary input low while running gives freewheel stop.
// - Keypad stop gives ramped stop in every command and wiring mode.
// - After a stop, run command must be seen low before restart.
// - 2-wire: restart after fault reset or power-up if run present.
// - 3-wire: start only on rising edge of forward or reverse input.
// - 3-wire: primary input low while running gives ramped stop.
// - 3-wire: no automatic restart after fault reset or power-up.
// - Motor selection honoured only on multi-rating variant; else redirect screen.
// - Multi-rating variant offers a choice of three motor ratings.
// - Assigned input low selects terminal mode, high selects keypad mode.
// - Primary input stays an override stop in keypad mode.
// - Keypad mode keeps last terminal direction and ignores direction changes.
`timescale 1ns/1ps
module drs_run_stop
   import drs_pkg::*;
#(
   parameter logic [15:0] REF_STEP = REF_STEP_DEFAULT,
   parameter logic [15:0] REF_MAX = REF_MAX_DEFAULT,
   parameter bit MULTI_RATING = 1'b0
) (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   // Keypad
   input wire drs_keys_s I_KEYS,
   input wire logic [15:0] I_ENTRY_VALUE,
   // Terminal strip
   input wire logic I_PRIMARY_LOGIC_INPUT,
   input wire logic I_FORWARD_INPUT,
   input wire logic I_REVERSE_INPUT,
   input wire logic I_COMMAND_SOURCE_BY_INPUT,
   input wire logic I_ASSIGNABLE_INPUT_A,
   input wire logic I_ASSIGNABLE_INPUT_B,
   input wire logic I_SOURCE_INPUT_SEL_B,
   input wire logic I_TERMINAL_REF_VALID,
   // Fault and configuration
   input wire logic I_FAULT_EVENT,
   input wire drs_cfg_s I_CFG,
   // Status
   output logic O_RUN_ACTIVE,
   output logic O_RAMP_STOP,
   output logic O_FREEWHEEL_STOP,
   output logic O_KEYPAD_MODE,
   output logic O_DIRECTION_REV,
   output logic [15:0] O_SPEED_REF,
   output logic O_FAULT_LATCHED,
   output logic [1:0] O_SCREEN,
   output logic O_CONFIG_OPEN,
   output logic O_CONFIG_REFUSED,
   output logic O_MOTOR_REDIRECT,
   output logic O_COMMAND_TYPE,
   output logic O_TORQUE_TYPE,
   output logic O_ALTERNATE_CONTROL_TYPE,
   output logic [1:0] O_MOTOR_RATING,
   output logic O_MOTOR_DEFAULTS_LOAD
);
   // Elaboration check: a zero step would freeze the arrow keys
   if (REF_STEP == 16'h0000) begin
      $error("REF_STEP must be non-zero");
   end

   drs_state_e state_reg, state_next;
   logic [15:0] ref_reg;
   logic [15:0] entry_reg;
   logic entry_armed_reg;
   logic fault_reg;
   logic cmd_live_reg;
   logic cmd_type_reg;
   logic torque_reg;
   logic ctrl_reg;
   logic [1:0] rating_reg;
   logic fwd_prev_reg;
   logic run_seen_low_reg;
   logic dir_reg;
   logic [1:0] screen_reg;
   logic cfg_open_reg;
   logic refused_reg;
   logic redirect_reg;
   logic defaults_reg;

   logic keypad_mode;
   logic running;
   logic run_cmd;
   logic fwd_rise;
   logic start_req;

   // Source by assigned input: high is keypad
   assign keypad_mode = I_COMMAND_SOURCE_BY_INPUT &&
      (I_SOURCE_INPUT_SEL_B ? I_ASSIGNABLE_INPUT_B : I_ASSIGNABLE_INPUT_A);
   assign running = (state_reg == DRS_RUNNING);
   assign run_cmd = I_FORWARD_INPUT || I_REVERSE_INPUT;
   assign fwd_rise = run_cmd && !fwd_prev_reg;

   always_comb begin
      start_req = 1'b0;
      if (keypad_mode) begin
         start_req = I_KEYS.run;
      end else if (cmd_live_reg == CMD_TWO_WIRE) begin
         start_req = run_cmd && run_seen_low_reg;
      end else begin
         start_req = fwd_rise && run_seen_low_reg;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         DRS_STOPPED, DRS_RAMPSTOP, DRS_FREEWHL: begin
            if (!fault_reg && I_PRIMARY_LOGIC_INPUT && start_req) begin
               state_next = DRS_RUNNING;
            end else begin
               state_next = DRS_STOPPED;
            end
         end
         DRS_RUNNING: begin
            if (fault_reg || I_FAULT_EVENT) begin
               state_next = DRS_FREEWHL;
            end else if (!I_PRIMARY_LOGIC_INPUT) begin
               // Override stop, also in keypad mode
               state_next = (cmd_live_reg == CMD_TWO_WIRE) ? DRS_FREEWHL : DRS_RAMPSTOP;
            end else if (I_KEYS.stop) begin
               state_next = DRS_RAMPSTOP;
            end else if (!keypad_mode && cmd_live_reg == CMD_TWO_WIRE && !run_cmd) begin
               state_next = DRS_RAMPSTOP;
            end
         end
         default: state_next = DRS_STOPPED;
      endcase
   end

   // Reset gives stopped state
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_reg <= DRS_STOPPED;
      end else begin
         state_reg <= state_next;
      end
   end

   // Run must be seen low after any stop unless a 2-wire fault is latched; 2-wire arms at power-up, 3-wire needs an edge
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         fwd_prev_reg <= 1'b1;
         run_seen_low_reg <= 1'b1;
      end else begin
         fwd_prev_reg <= run_cmd;
         if (state_next != DRS_RUNNING && running) begin
            run_seen_low_reg <= 1'b0;
         end else if (!run_cmd) begin
            run_seen_low_reg <= 1'b1;
         end else if (fault_reg && cmd_live_reg == CMD_TWO_WIRE) begin
            run_seen_low_reg <= 1'b1;
         end
      end
   end

   // Command type follows setting only while stopped
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         cmd_live_reg <= CMD_TYPE_RESET;
      end else if (state_reg == DRS_STOPPED) begin
         cmd_live_reg <= cmd_type_reg;
      end
   end

   // Keypad speed reference
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         ref_reg <= REF_RESET;
         entry_reg <= REF_RESET;
         entry_armed_reg <= 1'b0;
      end else if (keypad_mode) begin
         if (I_KEYS.dec_point) begin
            entry_armed_reg <= 1'b1;
            entry_reg <= I_ENTRY_VALUE;
         end else if (entry_armed_reg && I_KEYS.confirm) begin
            ref_reg <= (entry_reg > REF_MAX) ? REF_MAX : entry_reg;
            entry_armed_reg <= 1'b0;
         end else if (entry_armed_reg) begin
            entry_reg <= I_ENTRY_VALUE;
            if (I_KEYS.escape) entry_armed_reg <= 1'b0;
         end else if (I_KEYS.up) begin
            ref_reg <= (REF_MAX - ref_reg < REF_STEP) ? REF_MAX : ref_reg + REF_STEP;
         end else if (I_KEYS.down) begin
            ref_reg <= (ref_reg < REF_STEP) ? REF_RESET : ref_reg - REF_STEP;
         end
      end
   end

   // Fault latch: a new fault wins over reset
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         fault_reg <= 1'b0;
      end else if (I_FAULT_EVENT) begin
         fault_reg <= 1'b1;
      end else if (keypad_mode && I_KEYS.fault_reset_softkey) begin
         fault_reg <= 1'b0;
      end
   end

   // Direction frozen in keypad mode
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         dir_reg <= 1'b0;
      end else if (!keypad_mode) begin
         if (I_REVERSE_INPUT && !I_FORWARD_INPUT) dir_reg <= 1'b1;
         else if (I_FORWARD_INPUT) dir_reg <= 1'b0;
      end
   end

   // Screen scrolling
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         screen_reg <= SCREEN_RESET;
      end else if (keypad_mode ? I_KEYS.screen_cycle_softkey : I_KEYS.up) begin
         screen_reg <= screen_reg + 2'h1;
      end else if (!keypad_mode && I_KEYS.down) begin
         screen_reg <= screen_reg - 2'h1;
      end
   end

   // Configuration menu access and settings
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         cfg_open_reg <= 1'b0;
         refused_reg <= 1'b0;
         redirect_reg <= 1'b0;
         cmd_type_reg <= CMD_TYPE_RESET;
         torque_reg <= 1'b0;
         ctrl_reg <= 1'b0;
         rating_reg <= MOTOR_RATING_RESET;
         defaults_reg <= 1'b0;
      end else begin
         defaults_reg <= 1'b0;
         if (I_KEYS.escape) begin
            cfg_open_reg <= 1'b0;
            refused_reg <= 1'b0;
            redirect_reg <= 1'b0;
         end else if (I_CFG.enter_config) begin
            cfg_open_reg <= (state_reg == DRS_STOPPED);
            refused_reg <= (state_reg != DRS_STOPPED);
         end else if (redirect_reg && I_KEYS.confirm) begin
            redirect_reg <= 1'b0;
         end
         if (cfg_open_reg && state_reg == DRS_STOPPED) begin
            if (I_CFG.command_type_wr) cmd_type_reg <= I_CFG.command_type;
            if (I_CFG.torque_type_wr && I_CFG.torque_type != torque_reg) begin
               torque_reg <= I_CFG.torque_type;
               defaults_reg <= 1'b1;
            end
            if (I_CFG.control_type_wr && I_CFG.alternate_control_type != ctrl_reg) begin
               ctrl_reg <= I_CFG.alternate_control_type;
               defaults_reg <= 1'b1;
            end
            if (I_CFG.motor_select && !MULTI_RATING) redirect_reg <= 1'b1;
            if (MULTI_RATING && I_CFG.motor_rating_wr && I_CFG.motor_rating <= MOTOR_RATING_LAST) begin
               rating_reg <= I_CFG.motor_rating;
            end
         end
      end
   end

   assign O_RUN_ACTIVE = running;
   assign O_RAMP_STOP = (state_reg == DRS_RAMPSTOP);
   assign O_FREEWHEEL_STOP = (state_reg == DRS_FREEWHL);
   assign O_KEYPAD_MODE = keypad_mode;
   assign O_DIRECTION_REV = dir_reg;
   assign O_SPEED_REF = ref_reg;
   assign O_FAULT_LATCHED = fault_reg;
   assign O_SCREEN = screen_reg;
   assign O_CONFIG_OPEN = cfg_open_reg;
   assign O_CONFIG_REFUSED = refused_reg;
   assign O_MOTOR_REDIRECT = redirect_reg;
   assign O_COMMAND_TYPE = cmd_live_reg;
   assign O_TORQUE_TYPE = torque_reg;
   assign O_ALTERNATE_CONTROL_TYPE = ctrl_reg;
   assign O_MOTOR_RATING = rating_reg;
   assign O_MOTOR_DEFAULTS_LOAD = defaults_reg;

   a_twowire_freewheel: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      running && !I_PRIMARY_LOGIC_INPUT && cmd_live_reg == CMD_TWO_WIRE && !fault_reg && !I_FAULT_EVENT
      |=> state_reg == DRS_FREEWHL) else $error("2-wire input drop did not freewheel");
   a_threewire_ramp: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      running && !I_PRIMARY_LOGIC_INPUT && cmd_live_reg == CMD_THREE_WIRE && !fault_reg && !I_FAULT_EVENT
      |=> state_reg == DRS_RAMPSTOP) else $error("3-wire input drop did not ramp");
   a_stop_key_ramp: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      running && I_KEYS.stop && I_PRIMARY_LOGIC_INPUT && !fault_reg && !I_FAULT_EVENT
      |=> state_reg == DRS_RAMPSTOP) else $error("stop key did not ramp");
   a_ref_kept_stop: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      running && I_KEYS.stop && keypad_mode && !I_KEYS.up && !I_KEYS.down && !I_KEYS.dec_point && !entry_armed_reg
      |=> $stable(ref_reg)) else $error("reference changed on stop");
   a_up_key_step: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      keypad_mode && I_KEYS.up && !I_KEYS.dec_point && !entry_armed_reg && ref_reg <= REF_MAX - REF_STEP
      |=> ref_reg == $past(ref_reg) + REF_STEP) else $error("up key did not step reference");
   a_threewire_edge: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      state_reg == DRS_STOPPED && !keypad_mode && cmd_live_reg == CMD_THREE_WIRE && run_cmd && fwd_prev_reg
      |=> state_reg != DRS_RUNNING) else $error("3-wire started on held level");
   a_config_refused: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      I_CFG.enter_config && !I_KEYS.escape && running |=> refused_reg && !cfg_open_reg)
      else $error("config entry not refused while running");
   a_cmd_type_hold: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      state_reg != DRS_STOPPED |=> $stable(cmd_live_reg)) else $error("command type changed mid-run");
   a_fault_reset: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      keypad_mode && I_KEYS.fault_reset_softkey && !I_FAULT_EVENT |=> !fault_reg)
      else $error("fault not cleared by soft key");
endmodule

//--- verification/drs_pad.sv
// Model of the operator keypad and terminal strip driving the run/stop logic.
// Assumes the bench calls its tasks; every line changes at a falling clock edge.
`timescale 1ns/1ps
module drs_pad
   import drs_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Keypad
   output drs_keys_s o_keys,
   output logic [15:0] o_entry,
   // Terminal strip and configuration
   output logic o_primary,
   output logic o_forward,
   output logic o_by_input,
   output logic o_input_a,
   output logic o_fault,
   output drs_cfg_s o_cfg
);
   initial begin
      o_keys = '0;
      o_entry = 16'h0000;
      o_primary = 1'b1;
      o_forward = 1'b0;
      o_by_input = 1'b0;
      o_input_a = 1'b0;
      o_fault = 1'b0;
      o_cfg = '0;
   end

   // Keys and config strobes last one cycle
   task automatic key(input drs_keys_s k);
      @(negedge i_clk);
      o_keys = k;
      @(negedge i_clk);
      o_keys = '0;
   endtask

   task automatic cfg(input drs_cfg_s c);
      @(negedge i_clk);
      o_cfg = c;
      @(negedge i_clk);
      o_cfg = '0;
   endtask

   task automatic fault();
      @(negedge i_clk);
      o_fault = 1'b1;
      @(negedge i_clk);
      o_fault = 1'b0;
   endtask

   // Typed numeric entry, held until changed
   task automatic entry_set(input logic [15:0] v);
      @(negedge i_clk);
      o_entry = v;
   endtask

   // Held run enable or stop contact plus forward run command
   task automatic term(input logic p, input logic f);
      @(negedge i_clk);
      o_primary = p;
      o_forward = f;
   endtask

   // Assigned input high selects keypad control
   task automatic mode(input logic by_in, input logic a);
      @(negedge i_clk);
      o_by_input = by_in;
      o_input_a = a;
   endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the run/stop command logic.
// Assumes the keypad and terminal model drs_pad drives the operator lines; reverse input and assignable input B are tied low here.
`timescale 1ns/1ps
module tb;
   import drs_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   drs_keys_s keys;
   drs_cfg_s cfg;
   logic [15:0] entry;
   logic primary, forward, by_input, input_a, fault;
   logic run_active, ramp_stop, freewheel, keypad_mode, fault_latched, cfg_open, cfg_refused;
   logic redirect, cmd_type, defaults_load, torque_type, ctrl_type, dir_rev;
   logic [15:0] speed_ref;
   logic [1:0] screen, rating;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;

   drs_pad i_drs_pad (.i_clk(ref_clk), .o_keys(keys), .o_entry(entry), .o_primary(primary),
      .o_forward(forward), .o_by_input(by_input), .o_input_a(input_a), .o_fault(fault), .o_cfg(cfg));

   drs_run_stop i_drs_run_stop (.I_REF_CLK(ref_clk), .I_RST(rst), .I_KEYS(keys), .I_ENTRY_VALUE(entry),
      .I_PRIMARY_LOGIC_INPUT(primary), .I_FORWARD_INPUT(forward), .I_REVERSE_INPUT(1'b0),
      .I_COMMAND_SOURCE_BY_INPUT(by_input), .I_ASSIGNABLE_INPUT_A(input_a), .I_ASSIGNABLE_INPUT_B(1'b0),
      .I_SOURCE_INPUT_SEL_B(1'b0), .I_TERMINAL_REF_VALID(1'b0), .I_FAULT_EVENT(fault), .I_CFG(cfg),
      .O_RUN_ACTIVE(run_active), .O_RAMP_STOP(ramp_stop), .O_FREEWHEEL_STOP(freewheel),
      .O_KEYPAD_MODE(keypad_mode), .O_DIRECTION_REV(dir_rev), .O_SPEED_REF(speed_ref),
      .O_FAULT_LATCHED(fault_latched), .O_SCREEN(screen), .O_CONFIG_OPEN(cfg_open),
      .O_CONFIG_REFUSED(cfg_refused), .O_MOTOR_REDIRECT(redirect), .O_COMMAND_TYPE(cmd_type),
      .O_TORQUE_TYPE(torque_type), .O_ALTERNATE_CONTROL_TYPE(ctrl_type), .O_MOTOR_RATING(rating),
      .O_MOTOR_DEFAULTS_LOAD(defaults_load));

   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         stop_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic t_reset();
      chk(speed_ref, REF_RESET, "reference after reset");
      chk(run_active, 1'b0, "running after reset");
      chk(cmd_type, CMD_TWO_WIRE, "command type after reset");
      chk(rating, MOTOR_RATING_RESET, "rating after reset");
   endtask

   task automatic t_keypad();
      i_drs_pad.mode(1'b1, 1'b1);
      cyc(1);
      chk(keypad_mode, 1'b1, "keypad mode");
      i_drs_pad.key(drs_keys_s'{up: 1'b1, default: 1'b0});
      i_drs_pad.key(drs_keys_s'{up: 1'b1, default: 1'b0});
      chk(speed_ref, 16'h0002, "up twice");
      i_drs_pad.key(drs_keys_s'{down: 1'b1, default: 1'b0});
      chk(speed_ref, 16'h0001, "down");
      i_drs_pad.key(drs_keys_s'{run: 1'b1, default: 1'b0});
      chk(run_active, 1'b1, "run key");
      i_drs_pad.key(drs_keys_s'{down: 1'b1, default: 1'b0});
      chk(speed_ref, 16'h0000, "zero reference");
      chk(run_active, 1'b1, "running at zero");
      i_drs_pad.key(drs_keys_s'{up: 1'b1, default: 1'b0});
      i_drs_pad.key(drs_keys_s'{stop: 1'b1, default: 1'b0});
      chk(ramp_stop, 1'b1, "keypad stop ramps");
      chk(speed_ref, 16'h0001, "reference kept");
      i_drs_pad.key(drs_keys_s'{screen_cycle_softkey: 1'b1, default: 1'b0});
      chk(screen, 2'h1, "scroll soft key");
      i_drs_pad.fault();
      chk(fault_latched, 1'b1, "fault latched");
      i_drs_pad.key(drs_keys_s'{fault_reset_softkey: 1'b1, default: 1'b0});
      chk(fault_latched, 1'b0, "fault reset key");
      i_drs_pad.key(drs_keys_s'{run: 1'b1, default: 1'b0});
      i_drs_pad.term(1'b0, 1'b0);
      cyc(1);
      chk(run_active, 1'b0, "override stop in keypad mode");
      i_drs_pad.term(1'b1, 1'b0);
      i_drs_pad.key(drs_keys_s'{dec_point: 1'b1, default: 1'b0});
      i_drs_pad.entry_set(16'h1234);
      cyc(2);
      chk(speed_ref, 16'h0001, "entry before confirm");
      i_drs_pad.key(drs_keys_s'{confirm: 1'b1, default: 1'b0});
      chk(speed_ref, 16'h1234, "entry confirmed");
      i_drs_pad.mode(1'b1, 1'b0);
      cyc(1);
      chk(keypad_mode, 1'b0, "terminal mode");
   endtask

   task automatic t_two_wire();
      i_drs_pad.key(drs_keys_s'{up: 1'b1, default: 1'b0});
      chk(screen, 2'h2, "arrow scroll in terminal mode");
      i_drs_pad.term(1'b1, 1'b1);
      cyc(1);
      chk(run_active, 1'b1, "two-wire start");
      chk(dir_rev, 1'b0, "forward direction");
      i_drs_pad.term(1'b0, 1'b1);
      cyc(1);
      chk(freewheel, 1'b1, "run enable drop");
      i_drs_pad.term(1'b1, 1'b1);
      cyc(2);
      chk(run_active, 1'b0, "no restart while run held");
      i_drs_pad.term(1'b1, 1'b0);
      i_drs_pad.term(1'b1, 1'b1);
      cyc(1);
      chk(run_active, 1'b1, "restart after run low");
      i_drs_pad.cfg(drs_cfg_s'{enter_config: 1'b1, default: '0});
      chk(cfg_refused, 1'b1, "config while running");
      chk(cfg_open, 1'b0, "config not opened");
      i_drs_pad.key(drs_keys_s'{escape: 1'b1, default: 1'b0});
      chk(cfg_refused, 1'b0, "refusal cleared");
      i_drs_pad.key(drs_keys_s'{stop: 1'b1, default: 1'b0});
      chk(ramp_stop, 1'b1, "keypad stop in terminal mode");
      i_drs_pad.term(1'b1, 1'b0);
      cyc(2);
   endtask

   task automatic t_three_wire();
      i_drs_pad.cfg(drs_cfg_s'{enter_config: 1'b1, default: '0});
      chk(cfg_open, 1'b1, "config while stopped");
      i_drs_pad.cfg(drs_cfg_s'{command_type: CMD_THREE_WIRE, command_type_wr: 1'b1, default: '0});
      // Live command type follows the setting one cycle later while stopped
      cyc(1);
      chk(cmd_type, CMD_THREE_WIRE, "three-wire selected");
      i_drs_pad.cfg(drs_cfg_s'{torque_type: 1'b1, torque_type_wr: 1'b1, default: '0});
      chk(defaults_load, 1'b1, "defaults on torque change");
      chk(torque_type, 1'b1, "torque type written");
      i_drs_pad.cfg(drs_cfg_s'{alternate_control_type: 1'b1, control_type_wr: 1'b1, default: '0});
      chk(defaults_load, 1'b1, "defaults on control change");
      chk(ctrl_type, 1'b1, "control type written");
      i_drs_pad.cfg(drs_cfg_s'{motor_select: 1'b1, default: '0});
      chk(redirect, 1'b1, "single rating redirect");
      i_drs_pad.term(1'b1, 1'b1);
      cyc(1);
      chk(run_active, 1'b1, "start on forward edge");
      i_drs_pad.term(1'b0, 1'b1);
      cyc(1);
      chk(ramp_stop, 1'b1, "stop contact opens");
      i_drs_pad.term(1'b1, 1'b1);
      cyc(2);
      chk(run_active, 1'b0, "held level does not start");
      i_drs_pad.term(1'b1, 1'b0);
      i_drs_pad.term(1'b1, 1'b1);
      cyc(1);
      chk(run_active, 1'b1, "fresh edge restarts");
   endtask

   initial begin
      cyc(5);
      rst = 1'b0;
      cyc(1);
      t_reset();
      t_keypad();
      t_two_wire();
      t_three_wire();
      stop_test();
   end
endmodule
